/* File: hdl/msd_top.sv */
// Purpose: Load reading, velocity-gated stall detection and stall diagnostic outputs.
// Assumes: Step, measurement and step-interval inputs come from logic on ref_clk_in.
// Notes:   Registers are reached over Avalon-MM; every access takes one wait cycle.
//
// Overview of operation
// R1: Refresh the load reading once per full step when filtering is off.
// R2: With filtering on, report the average of four consecutive load measurements.
// R3: The load threshold offset is a two's complement signed value.
// R4: A zero load reading raises the stall indication while detection is enabled.
// R5: Either diagnostic output can be selected to carry the stall pulse.
// R6: No stall detection while lower limit does not exceed the step interval.
// R7: No stall detection while velocity is above the upper limit.
// R8: The external controller stops the motor on a single stall pulse.
// R9: A larger offset raises the reading, saturating at the maximum value.
// R10: The load reading is a ten-bit unsigned value.
// R11: With filtering on, one result per four full steps.
// R12: The lower limit is judged by comparing it with the measured step interval.
// R13: Stall pulse spans the step of a gated zero reading until next update.
`timescale 1ns/10ps
`default_nettype none
module msd_top (
  // Clock and reset
  input  wire logic                              ref_clk_in,
  input  wire logic                              nrst_in,
  // Motor side
  input  wire logic                              fullstep_in,
  input  wire logic [msd_pkg::READING_W-1:0]     load_value_in,
  input  wire logic [msd_pkg::INTERVAL_W-1:0]    step_interval_in,
  // Avalon-MM slave
  input  wire logic [msd_pkg::ADDR_W-1:0]        avs_address_in,
  input  wire logic                              avs_read_in,
  input  wire logic                              avs_write_in,
  input  wire logic [msd_pkg::DATA_W-1:0]        avs_writedata_in,
  input  wire logic [msd_pkg::BE_W-1:0]          avs_byteenable_in,
  output logic [msd_pkg::DATA_W-1:0]             avs_readdata_out,
  output logic                                   avs_waitrequest_out,
  // Results and diagnostics
  output logic [msd_pkg::READING_W-1:0]          load_reading_out,
  output logic                                   stall_out,
  output logic                                   diag_out_zero_out,
  output logic                                   diag_out_one_out,
  output logic                                   irq_out
);

  msd_pkg::msd_cfg_t                 cfg_reg;
  logic [msd_pkg::INTERVAL_W-1:0]    lower_velocity_limit_reg;
  logic [msd_pkg::INTERVAL_W-1:0]    upper_velocity_limit_reg;
  logic [msd_pkg::IRQ_W-1:0]         status_reg;
  logic [msd_pkg::IRQ_W-1:0]         status_next;
  logic [msd_pkg::IRQ_W-1:0]         int_enable_reg;
  logic [msd_pkg::DATA_W-1:0]        wmask;
  logic [msd_pkg::DATA_W-1:0]        cfg_word;
  logic [msd_pkg::DATA_W-1:0]        cfg_word_next;
  logic [msd_pkg::DATA_W-1:0]        lower_word_next;
  logic [msd_pkg::DATA_W-1:0]        upper_word_next;
  logic [msd_pkg::DATA_W-1:0]        rd_mux;
  logic [msd_pkg::IRQ_W-1:0]         events;
  logic [msd_pkg::IRQ_W-1:0]         clear_bits;
  logic [msd_pkg::READING_W-1:0]     load_reading;
  logic                              reading_update;
  logic                              req;
  logic                              accept;
  logic                              wr_accept;
  logic                              sel_cfg;
  logic                              sel_lower;
  logic                              sel_upper;
  logic                              sel_reading;
  logic                              sel_status;
  logic                              sel_enable;
  logic                              sel_clear;
  logic                              above_lower;
  logic                              below_upper;
  logic                              window_ok;
  logic                              stall_hit;
  logic                              stall_reg;
  logic                              stall_next;

  // ****************************************************************
  // Load measurement path
  // ****************************************************************
  msd_load_conditioner u_cond (
    .ref_clk_in   (ref_clk_in),
    .nrst_in      (nrst_in),
    .sample_in    (fullstep_in),
    .raw_in       (load_value_in),
    .filter_en_in (cfg_reg.filter_en),
    .offset_in    (cfg_reg.offset),
    .update_out   (reading_update),
    .reading_out  (load_reading)
  );

  assign load_reading_out = load_reading; // R10

  // ****************************************************************
  // Velocity window
  // ****************************************************************
  // A short step interval means high velocity, so the comparisons run inverted.
  assign above_lower = (lower_velocity_limit_reg > step_interval_in); // R6 R12
  assign below_upper = (step_interval_in >= upper_velocity_limit_reg); // R7
  assign window_ok   = above_lower && below_upper;

  // ****************************************************************
  // Stall detection
  // ****************************************************************
  // The pulse is rearmed only by a reading update, so one stall gives one pulse
  // per reading update, which is all the external controller needs to stop the motor.
  assign stall_hit  = reading_update && (load_reading == msd_pkg::READING_RST)
                      && cfg_reg.stall_en && window_ok; // R4 R6 R7
  assign stall_next = reading_update ? stall_hit : stall_reg; // R13

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stall_reg         <= 1'b0;
      stall_out         <= 1'b0;
      diag_out_zero_out <= 1'b0;
      diag_out_one_out  <= 1'b0;
    end else begin
      stall_reg         <= stall_next; // R13
      stall_out         <= stall_next; // R4 R8
      diag_out_zero_out <= stall_next && cfg_reg.diag0_sel; // R5
      diag_out_one_out  <= stall_next && cfg_reg.diag_out_one_sel; // R5
    end
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign req         = avs_read_in || avs_write_in;
  assign accept      = req && !avs_waitrequest_out;
  assign wr_accept   = accept && avs_write_in;
  assign sel_cfg     = (avs_address_in == msd_pkg::CONFIG_ADDR);
  assign sel_lower   = (avs_address_in == msd_pkg::LOWER_ADDR);
  assign sel_upper   = (avs_address_in == msd_pkg::UPPER_ADDR);
  assign sel_reading = (avs_address_in == msd_pkg::READING_ADDR);
  assign sel_status  = (avs_address_in == msd_pkg::STATUS_ADDR);
  assign sel_enable  = (avs_address_in == msd_pkg::INT_ENABLE_ADDR);
  assign sel_clear   = (avs_address_in == msd_pkg::INT_CLEAR_ADDR);

  genvar lane;
  generate
    for (lane = 0; lane < msd_pkg::BE_W; lane++) begin : g_lane
      assign wmask[lane*8 +: 8] = {8{avs_byteenable_in[lane]}};
    end
  endgenerate

  assign cfg_word = {14'h0,
                     cfg_reg.diag_out_one_sel,
                     cfg_reg.diag0_sel,
                     3'h0,
                     cfg_reg.stall_en,
                     3'h0,
                     cfg_reg.filter_en,
                     1'b0,
                     cfg_reg.offset};

  assign cfg_word_next   = (cfg_word & ~wmask) | (avs_writedata_in & wmask);
  assign lower_word_next = ({12'h000, lower_velocity_limit_reg} & ~wmask)
                         | (avs_writedata_in & wmask);
  assign upper_word_next = ({12'h000, upper_velocity_limit_reg} & ~wmask)
                         | (avs_writedata_in & wmask);

  assign rd_mux = sel_cfg     ? cfg_word :
                  sel_lower   ? {12'h000, lower_velocity_limit_reg} :
                  sel_upper   ? {12'h000, upper_velocity_limit_reg} :
                  sel_reading ? {22'h0, load_reading} :
                  sel_status  ? {30'h0, status_reg} :
                  sel_enable  ? {30'h0, int_enable_reg} :
                  msd_pkg::DATA_ZERO;

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // Waitrequest idles high and drops for exactly one cycle per request.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= msd_pkg::DATA_ZERO;
    end else begin
      avs_waitrequest_out <= !(req && avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_reg                  <= msd_pkg::CFG_RST;
      lower_velocity_limit_reg <= msd_pkg::LIMIT_RST;
      upper_velocity_limit_reg <= msd_pkg::LIMIT_RST;
      int_enable_reg           <= msd_pkg::IRQ_RST;
    end else if (wr_accept) begin
      if (sel_cfg) begin
        cfg_reg.offset    <= cfg_word_next[msd_pkg::CFG_OFFSET_LSB +: msd_pkg::OFFSET_W]; // R3
        cfg_reg.filter_en <= cfg_word_next[msd_pkg::CFG_FILTER_BIT]; // R2
        cfg_reg.stall_en  <= cfg_word_next[msd_pkg::CFG_STALL_BIT];
        cfg_reg.diag0_sel <= cfg_word_next[msd_pkg::CFG_DIAG0_BIT]; // R5
        cfg_reg.diag_out_one_sel <= cfg_word_next[msd_pkg::CFG_DIAG_OUT_ONE_BIT]; // R5
      end
      if (sel_lower) begin
        lower_velocity_limit_reg <= lower_word_next[msd_pkg::INTERVAL_W-1:0];
      end
      if (sel_upper) begin
        upper_velocity_limit_reg <= upper_word_next[msd_pkg::INTERVAL_W-1:0];
      end
      if (sel_enable && avs_byteenable_in[0]) begin
        int_enable_reg <= avs_writedata_in[msd_pkg::IRQ_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // A new event in the clearing cycle survives, so no stall is ever lost.
  assign events[msd_pkg::ST_STALL_BIT]  = stall_hit;
  assign events[msd_pkg::ST_UPDATE_BIT] = reading_update;
  assign clear_bits = (wr_accept && sel_clear && avs_byteenable_in[0]) ?
                      avs_writedata_in[msd_pkg::IRQ_W-1:0] : msd_pkg::IRQ_RST;
  assign status_next = (status_reg & ~clear_bits) | events;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_reg <= msd_pkg::IRQ_RST;
      irq_out    <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_out    <= |(status_next & int_enable_reg);
    end
  end

endmodule
`default_nettype wire

/* File: inc/msd_pkg.sv */
// Purpose: Shared constants and types of the motor stall detector.
// Assumes: 32-bit Avalon-MM register bus with byte addresses.
// Notes:   Register offsets, field positions and register reset values used by the design live here.
package msd_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned READING_W  = 10;
  localparam int unsigned OFFSET_W   = 7;
  localparam int unsigned INTERVAL_W = 20;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned BE_W       = 4;
  localparam int unsigned SUM_W      = 13;
  localparam int unsigned ACC_W      = 12;
  localparam int unsigned OFFSET_SH  = 5;
  localparam int unsigned AVG_SH     = 2;
  localparam int unsigned IRQ_W      = 2;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [ADDR_W-1:0] CONFIG_ADDR     = 8'h00;
  localparam logic [ADDR_W-1:0] LOWER_ADDR      = 8'h04;
  localparam logic [ADDR_W-1:0] UPPER_ADDR      = 8'h08;
  localparam logic [ADDR_W-1:0] READING_ADDR    = 8'h0c;
  localparam logic [ADDR_W-1:0] STATUS_ADDR     = 8'h10;
  localparam logic [ADDR_W-1:0] INT_ENABLE_ADDR = 8'h14;
  localparam logic [ADDR_W-1:0] INT_CLEAR_ADDR  = 8'h18;

  // ****************************************************************
  // Field positions of the configuration register
  // ****************************************************************
  localparam int unsigned CFG_OFFSET_LSB = 0;
  localparam int unsigned CFG_FILTER_BIT = 8;
  localparam int unsigned CFG_STALL_BIT  = 12;
  localparam int unsigned CFG_DIAG0_BIT  = 16;
  localparam int unsigned CFG_DIAG_OUT_ONE_BIT  = 17;

  // ****************************************************************
  // Status and interrupt bit positions
  // ****************************************************************
  localparam int unsigned ST_STALL_BIT  = 0;
  localparam int unsigned ST_UPDATE_BIT = 1;

  // ****************************************************************
  // Numeric limits and reset values
  // ****************************************************************
  localparam logic [READING_W-1:0]  READING_MAX   = 10'h3ff;
  localparam logic [READING_W-1:0]  READING_RST   = 10'h000;
  localparam logic [INTERVAL_W-1:0] LIMIT_RST     = 20'h00000;
  localparam logic [IRQ_W-1:0]      IRQ_RST       = 2'h0;
  localparam logic [1:0]            FILTER_LAST   = 2'h3;
  localparam logic [DATA_W-1:0]     DATA_ZERO     = 32'h00000000;

  typedef struct packed {
    logic                diag_out_one_sel;
    logic                diag0_sel;
    logic                stall_en;
    logic                filter_en;
    logic [OFFSET_W-1:0] offset;
  } msd_cfg_t;

  localparam msd_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 7'h00};

endpackage

/* File: hdl/msd_load_conditioner.sv */
// Purpose: Offsets each raw load measurement and optionally averages four of them.
// Assumes: sample_in is a one-cycle pulse per full step from logic on the same clock.
// Notes:   The result register is the load reading seen by software and by stall logic.
`timescale 1ns/10ps
`default_nettype none
module msd_load_conditioner (
  // Clock and reset
  input  wire logic                              ref_clk_in,
  input  wire logic                              nrst_in,
  // Measurement
  input  wire logic                              sample_in,
  input  wire logic [msd_pkg::READING_W-1:0]     raw_in,
  // Configuration
  input  wire logic                              filter_en_in,
  input  wire logic [msd_pkg::OFFSET_W-1:0]      offset_in,
  // Result
  output logic                                   update_out,
  output logic [msd_pkg::READING_W-1:0]          reading_out
);

  logic signed [msd_pkg::SUM_W-1:0]  sum;
  logic [msd_pkg::READING_W-1:0]     adjusted;
  logic [msd_pkg::ACC_W-1:0]         acc_reg;
  logic [msd_pkg::ACC_W-1:0]         acc_next;
  logic [1:0]                        cnt_reg;
  logic                              last_of_four;

  // ****************************************************************
  // Signed offset, scaled to the reading range, with saturation
  // ****************************************************************
  assign sum = $signed({3'h0, raw_in})
             + $signed({offset_in[msd_pkg::OFFSET_W-1], offset_in, 5'h00}); // R3 R9
  assign adjusted = sum[msd_pkg::SUM_W-1] ? msd_pkg::READING_RST :
                    (sum[msd_pkg::SUM_W-2:msd_pkg::READING_W] != 2'h0) ? msd_pkg::READING_MAX :
                    sum[msd_pkg::READING_W-1:0]; // R9 R10

  // ****************************************************************
  // Four-measurement average
  // ****************************************************************
  assign acc_next     = acc_reg + {2'h0, adjusted};
  assign last_of_four = (cnt_reg == msd_pkg::FILTER_LAST);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_reg     <= 12'h000;
      cnt_reg     <= 2'h0;
      update_out  <= 1'b0;
      reading_out <= msd_pkg::READING_RST;
    end else begin
      update_out <= 1'b0;
      if (!filter_en_in) begin
        acc_reg <= 12'h000;
        cnt_reg <= 2'h0;
        if (sample_in) begin
          reading_out <= adjusted; // R1
          update_out  <= 1'b1;
        end
      end else if (sample_in) begin
        cnt_reg <= cnt_reg + 2'h1;
        if (last_of_four) begin
          acc_reg     <= 12'h000;
          reading_out <= acc_next[msd_pkg::ACC_W-1:msd_pkg::AVG_SH]; // R2 R11
          update_out  <= 1'b1;
        end else begin
          acc_reg <= acc_next;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: test/msd_checker.sv */
// Purpose: Port-level concurrent checks of the stall detector.
// Assumes: One clock domain and an active-low asynchronous reset.
// Notes:   Configuration is not visible here, so outputs are tied to port events.
`timescale 1ns/10ps
`default_nettype none
module msd_checker (
  // Clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          nrst_in,
  // Watched inputs
  input  wire logic                          fullstep_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  // Watched outputs
  input  wire logic                          avs_waitrequest_out,
  input  wire logic [msd_pkg::READING_W-1:0] load_reading_out,
  input  wire logic                          stall_out,
  input  wire logic                          diag_out_zero_out,
  input  wire logic                          diag_out_one_out,
  input  wire logic                          irq_out
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_answer;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_wait_one;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_cause;
    $fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_update;
    $changed(load_reading_out) |-> $past(fullstep_in);
  endproperty
  a_update: assert property (p_update) else $error("reading moved off a step");
  property p_stall_zero;
    $rose(stall_out) |-> $past(load_reading_out) == 10'h000;
  endproperty
  a_stall_zero: assert property (p_stall_zero) else $error("stall on nonzero");
  property p_stall_time;
    $changed(stall_out) |-> $past(fullstep_in, 2);
  endproperty
  a_stall_time: assert property (p_stall_time) else $error("stall moved off update");
  property p_diag0;
    diag_out_zero_out |-> stall_out;
  endproperty
  a_diag0: assert property (p_diag0) else $error("diag zero without stall");
  property p_diag_out_one;
    diag_out_one_out |-> stall_out;
  endproperty
  a_diag_out_one: assert property (p_diag_out_one) else $error("diag one without stall");
  property p_irq;
    $rose(irq_out) |-> $past(fullstep_in, 2) || $past(avs_write_in, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without event");
endmodule

bind msd_top msd_checker u_chk (
  .ref_clk_in          (ref_clk_in),
  .nrst_in             (nrst_in),
  .fullstep_in         (fullstep_in),
  .avs_read_in         (avs_read_in),
  .avs_write_in        (avs_write_in),
  .avs_waitrequest_out (avs_waitrequest_out),
  .load_reading_out    (load_reading_out),
  .stall_out           (stall_out),
  .diag_out_zero_out   (diag_out_zero_out),
  .diag_out_one_out    (diag_out_one_out),
  .irq_out             (irq_out)
);
`default_nettype wire

/* File: test/msd_motion_ctrl.sv */
// Purpose: Model of the external motion controller watching a stall output.
// Assumes: The stall line is a registered level on the same clock.
// Notes:   Counts rising edges so a long pulse is one event, not many.
`timescale 1ns/10ps
`default_nettype none
module msd_motion_ctrl (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  // Stall line and reaction
  input  wire logic       stall_in,
  output logic            stop_out,
  output logic [7:0]      pulses_out
);
  logic stall_q;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stall_q <= 1'b0;
      stop_out <= 1'b0;
      pulses_out <= 8'h00;
    end else begin
      stall_q <= stall_in;
      if (stall_in && !stall_q) begin
        stop_out <= 1'b1;
        pulses_out <= pulses_out + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Purpose: Directed test of load reading, stall gating and register access.
// Assumes: Avalon-MM where waitrequest alone ends a transfer; byte lanes are all enabled.
// Notes:   Expected readings follow clamp(raw + offset*32) and the four-sample mean.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                          ref_clk_in = 1'b0;
  logic                          nrst_in = 1'b0;
  logic                          fullstep_in = 1'b0;
  logic [msd_pkg::READING_W-1:0] load_value_in = 10'h000;
  logic [msd_pkg::INTERVAL_W-1:0] step_interval_in = 20'h00080;
  logic [msd_pkg::ADDR_W-1:0]    avs_address_in = 8'h00;
  logic                          avs_read_in = 1'b0;
  logic                          avs_write_in = 1'b0;
  logic [msd_pkg::DATA_W-1:0]    avs_writedata_in = 32'h00000000;
  logic [msd_pkg::DATA_W-1:0]    avs_readdata_out;
  logic [msd_pkg::DATA_W-1:0]    q;
  logic [msd_pkg::DATA_W-1:0]    rd_q;
  logic                          wait_q;
  logic [msd_pkg::READING_W-1:0] load_reading_out;
  logic                          avs_waitrequest_out;
  logic                          stall_out;
  logic                          diag_out_zero_out;
  logic                          diag_out_one_out;
  logic                          irq_out;
  logic                          stop;
  logic [7:0]                    pulses;
  int                            n_errors = 0;
  int                            checked = 0;
  int                            cycles = 0;
  logic [19:0] iv [4] = '{20'h00100, 20'h000ff, 20'h0000f, 20'h00010};
  logic [6:0]  ofs [4] = '{7'h7f, 7'h1f, 7'h40, 7'h01};
  logic [9:0]  raw [4] = '{10'h040, 10'h3f0, 10'h010, 10'h100};
  logic [9:0]  exr [4] = '{10'h020, 10'h3ff, 10'h000, 10'h120};

  always #2.5 ref_clk_in = ~ref_clk_in;

  // Bus answers are sampled mid-cycle so the rising edge never races the design.
  always @(negedge ref_clk_in) begin
    wait_q <= avs_waitrequest_out;
    rd_q   <= avs_readdata_out;
  end

  msd_top u_dut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .fullstep_in(fullstep_in),
    .load_value_in(load_value_in), .step_interval_in(step_interval_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .load_reading_out(load_reading_out),
    .stall_out(stall_out), .diag_out_zero_out(diag_out_zero_out),
    .diag_out_one_out(diag_out_one_out), .irq_out(irq_out));
  msd_motion_ctrl u_ctrl (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .stall_in(diag_out_one_out | diag_out_zero_out), .stop_out(stop), .pulses_out(pulses));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic close_out();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request stays up until the edge that samples waitrequest low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge ref_clk_in);
    while (wait_q !== 1'b0) @(posedge ref_clk_in);
    q = rd_q;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask

  task automatic step(input logic [9:0] r);
    @(posedge ref_clk_in);
    fullstep_in <= 1'b1;
    load_value_in <= r;
    @(posedge ref_clk_in);
    fullstep_in <= 1'b0;
    load_value_in <= ~r;
    repeat (2) @(posedge ref_clk_in);
  endtask

  function automatic logic [31:0] mk(input logic [6:0] o, input logic f, s, d0, d1);
    mk = 32'h00000000;
    mk[6:0] = o;
    mk[msd_pkg::CFG_FILTER_BIT] = f;
    mk[msd_pkg::CFG_STALL_BIT] = s;
    mk[msd_pkg::CFG_DIAG0_BIT] = d0;
    mk[msd_pkg::CFG_DIAG_OUT_ONE_BIT] = d1;
  endfunction

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    rd(msd_pkg::CONFIG_ADDR, 32'h00000000);
    rd(msd_pkg::STATUS_ADDR, 32'h00000000);
    bus(1'b1, 8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h00000000);
    bus(1'b1, msd_pkg::LOWER_ADDR, 32'h00000100);
    bus(1'b1, msd_pkg::UPPER_ADDR, 32'h00000010);
    bus(1'b1, msd_pkg::CONFIG_ADDR, mk(7'h00, 1'b0, 1'b1, 1'b0, 1'b1));
    rd(msd_pkg::LOWER_ADDR, 32'h00000100);
    step(10'h000);
    chk({stall_out, diag_out_one_out, diag_out_zero_out, irq_out}, 32'hc);
    rd(msd_pkg::STATUS_ADDR, 32'h00000003);
    chk({31'h0, stop}, 32'h1);
    bus(1'b1, msd_pkg::INT_ENABLE_ADDR, 32'h00000001);
    rd(msd_pkg::INT_ENABLE_ADDR, 32'h00000001);
    chk({31'h0, irq_out}, 32'h1);
    bus(1'b1, msd_pkg::INT_CLEAR_ADDR, 32'h00000003);
    rd(msd_pkg::STATUS_ADDR, 32'h00000000);
    chk({31'h0, irq_out}, 32'h0);
    step(10'h200);
    chk({stall_out, 6'h0, load_reading_out}, 32'h200);
    bus(1'b1, msd_pkg::CONFIG_ADDR, mk(7'h00, 1'b0, 1'b1, 1'b1, 1'b0));
    step(10'h000);
    chk({stall_out, diag_out_one_out, diag_out_zero_out}, 32'h5);
    // Limits: lower 0x100, upper 0x010; the window is upper <= interval < lower.
    for (int i = 0; i < 4; i++) begin
      step_interval_in <= iv[i];
      step(10'h000);
      chk({31'h0, stall_out}, {31'h0, i[0]});
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, msd_pkg::CONFIG_ADDR, mk(ofs[i], 1'b0, 1'b0, 1'b0, 1'b0));
      step(raw[i]);
      chk({22'h0, load_reading_out}, {22'h0, exr[i]});
    end
    bus(1'b1, msd_pkg::CONFIG_ADDR, mk(7'h00, 1'b1, 1'b0, 1'b0, 1'b0));
    for (int i = 1; i < 4; i++) begin
      step(10'(i * 256));
      chk({22'h0, load_reading_out}, 32'h120);
    end
    step(10'h000);
    chk({22'h0, load_reading_out}, 32'h180);
    bus(1'b1, msd_pkg::READING_ADDR, 32'h00000000);
    rd(msd_pkg::READING_ADDR, 32'h00000180);
    chk({24'h0, pulses}, 32'h4);
    close_out();
  end
endmodule
`default_nettype wire
